// *** hdl/eir_pkg.sv ***
package eir_pkg;
  // register widths and offsets
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam int PORT_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_PA_DATA = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_PA_DIR = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_OPT_ONE = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_OPT_TWO = 3'h5;
  localparam logic [ADDR_W-1:0] ADDR_PA_PINS = 3'h6;
  // status and mask bit positions
  localparam int ST_LATCHED = 0;
  localparam int ST_TAKEN = 1;
  // option register one: sensitivity bit
  localparam int OPT_LEVEL_BIT = 0;
  // reset values
  localparam logic [DATA_W-1:0] RST_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] RST_OPT_ONE = 8'h00;
  localparam logic [DATA_W-1:0] RST_OPT_TWO = 8'h00;
  localparam int SYNC_STAGES = 2;
endpackage

// *** hdl/eir_sync_if.sv ***
`timescale 1ns/1ns
`default_nettype none
// synchronised request lines passed from the sampler to the controller
interface eir_sync_if #(parameter int W = 9);
  logic [W-1:0] level;
  logic [W-1:0] prev;
  modport src (output level, output prev);
  modport dst (input level, input prev);
endinterface
`default_nettype wire

// *** hdl/eir_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
// two-stage synchroniser plus a history stage for edge detection
module eir_sync #(
  parameter int W = 9,
  parameter logic [W-1:0] IDLE = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] pins,
  eir_sync_if.src sy
);
  logic [W-1:0] meta_q;
  logic [W-1:0] stab_q;
  logic [W-1:0] prev_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= IDLE;
      stab_q <= IDLE;
      prev_q <= IDLE;
    end else begin
      meta_q <= pins;
      stab_q <= meta_q;
      prev_q <= stab_q;
    end
  end

  assign sy.level = stab_q;
  assign sy.prev = prev_q;
endmodule
`default_nettype wire

// *** hdl/eir_top.sv ***
//Contract
//- a low request line sets an internal pending latch
//- the request is answered only after the current instruction completes
//- at instruction end, start sequence if latch set and mask flag clear
//- option selects falling-edge only or edge plus low level sensitivity
//- each port A pin has its own request and pullup enable option
//- after reset every port A line is an input
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module eir_top #(
  parameter int PORT_W = eir_pkg::PORT_W,
  parameter logic [eir_pkg::DATA_W-1:0] OPT_ONE_RST = eir_pkg::RST_OPT_ONE,
  parameter logic [eir_pkg::DATA_W-1:0] OPT_TWO_RST = eir_pkg::RST_OPT_TWO
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic irq_n,
  input wire logic [PORT_W-1:0] port_a_pins_in,
  output logic [PORT_W-1:0] port_a_pins_out,
  output logic [PORT_W-1:0] port_a_pins_oe,
  output logic [PORT_W-1:0] port_a_pullup_en,
  input wire logic instr_done,
  input wire logic cc_irq_mask,
  output logic irq_take,
  output logic irq_pending,
  output logic irq_out,
  input wire logic [eir_pkg::ADDR_W-1:0] addr,
  input wire logic [eir_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [eir_pkg::DATA_W-1:0] rdata
);
  localparam int SW = PORT_W + 1;

  logic [eir_pkg::DATA_W-1:0] status_q;
  logic [eir_pkg::DATA_W-1:0] mask_q;
  logic [PORT_W-1:0] pa_data_q;
  logic [PORT_W-1:0] pa_dir_q;
  logic [eir_pkg::DATA_W-1:0] opt_one_q;
  logic [PORT_W-1:0] opt_two_q;
  logic latch_q;
  logic take_q;
  logic irq_out_q;
  logic [eir_pkg::DATA_W-1:0] rdata_q;
  logic line_now;
  logic line_prev;
  logic req_set;
  logic take_d;
  logic [eir_pkg::DATA_W-1:0] status_set;
  logic [eir_pkg::DATA_W-1:0] rdata_d;
  logic [eir_pkg::DATA_W-1:0] status_d;
  logic wr_status;
  logic wr_mask;
  logic wr_pa_data;
  logic wr_pa_dir;
  logic wr_opt_one;
  logic wr_opt_two;

  eir_sync_if #(.W(SW)) sy ();

  // pin and port A sampling into the clock domain
  eir_sync #(.W(SW), .IDLE('1)) u_sync (
    .clk(clk),
    .rst(rst),
    .pins({port_a_pins_in, irq_n}),
    .sy(sy)
  );

  // wired request line: pin low or any enabled port A pin low
  always_comb begin
    line_now = sy.level[0] & &(sy.level[SW-1:1] | ~opt_two_q);
    line_prev = sy.prev[0] & &(sy.prev[SW-1:1] | ~opt_two_q);
  end

  // falling edge always requests; low level only when selected
  always_comb begin
    req_set = (line_prev & ~line_now)
      | (opt_one_q[eir_pkg::OPT_LEVEL_BIT] & ~line_now);
  end

  // answer only at an instruction boundary with the mask flag clear
  assign take_d = instr_done & latch_q & ~cc_irq_mask;

  // pending latch; a new request beats the clear on entry
  always_ff @(posedge clk) begin
    if (rst) begin
      latch_q <= 1'b0;
    end else if (req_set) begin
      latch_q <= 1'b1;
    end else if (take_d) begin
      latch_q <= 1'b0;
    end
  end

  // sequence start pulse to the instruction sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      take_q <= 1'b0;
    end else begin
      take_q <= take_d;
    end
  end

  // sticky event bits, write one to clear, set wins
  always_comb begin
    status_set = eir_pkg::RST_ZERO;
    status_set[eir_pkg::ST_LATCHED] = req_set & ~latch_q;
    status_set[eir_pkg::ST_TAKEN] = take_d;
  end

  // write strobe decode, one per writable register
  assign wr_status = wr && (addr == eir_pkg::ADDR_STATUS);
  assign wr_mask = wr && (addr == eir_pkg::ADDR_MASK);
  assign wr_pa_data = wr && (addr == eir_pkg::ADDR_PA_DATA);
  assign wr_pa_dir = wr && (addr == eir_pkg::ADDR_PA_DIR);
  assign wr_opt_one = wr && (addr == eir_pkg::ADDR_OPT_ONE);
  assign wr_opt_two = wr && (addr == eir_pkg::ADDR_OPT_TWO);

  // next status: written ones clear, a new event still sets
  always_comb begin
    status_d = status_q | status_set;
    if (wr_status) begin
      status_d = (status_q & ~wdata) | status_set;
    end
  end

  // status register
  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= eir_pkg::RST_ZERO;
    end else begin
      status_q <= status_d;
    end
  end

  // interrupt level output from unmasked status
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_out_q <= 1'b0;
    end else begin
      irq_out_q <= |(status_q & mask_q);
    end
  end

  // interrupt mask register, same layout as status
  always_ff @(posedge clk) begin
    if (rst) begin
      mask_q <= eir_pkg::RST_ZERO;
    end else if (wr_mask) begin
      mask_q <= wdata;
    end
  end

  // port A output data
  always_ff @(posedge clk) begin
    if (rst) begin
      pa_data_q <= PORT_W'(eir_pkg::RST_ZERO);
    end else if (wr_pa_data) begin
      pa_data_q <= wdata[PORT_W-1:0];
    end
  end

  // port A direction, every line an input out of reset
  always_ff @(posedge clk) begin
    if (rst) begin
      pa_dir_q <= PORT_W'(eir_pkg::RST_ZERO);
    end else if (wr_pa_dir) begin
      pa_dir_q <= wdata[PORT_W-1:0];
    end
  end

  // option one: request sensitivity select
  always_ff @(posedge clk) begin
    if (rst) begin
      opt_one_q <= OPT_ONE_RST;
    end else if (wr_opt_one) begin
      opt_one_q <= wdata;
    end
  end

  // option two: per-pin request and pullup enable
  always_ff @(posedge clk) begin
    if (rst) begin
      opt_two_q <= OPT_TWO_RST[PORT_W-1:0];
    end else if (wr_opt_two) begin
      opt_two_q <= wdata[PORT_W-1:0];
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    case (addr)
      eir_pkg::ADDR_STATUS: rdata_d = status_q;
      eir_pkg::ADDR_MASK: rdata_d = mask_q;
      eir_pkg::ADDR_PA_DATA: rdata_d = pa_data_q;
      eir_pkg::ADDR_PA_DIR: rdata_d = pa_dir_q;
      eir_pkg::ADDR_OPT_ONE: rdata_d = opt_one_q;
      eir_pkg::ADDR_OPT_TWO: rdata_d = opt_two_q;
      eir_pkg::ADDR_PA_PINS: rdata_d = sy.level[SW-1:1];
      default: rdata_d = eir_pkg::RST_ZERO;
    endcase
  end

  // read data stands one cycle after the strobe only
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= eir_pkg::RST_ZERO;
    end else if (rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= eir_pkg::RST_ZERO;
    end
  end

  assign port_a_pins_out = pa_data_q;
  assign port_a_pins_oe = pa_dir_q;
  assign port_a_pullup_en = opt_two_q;
  assign irq_take = take_q;
  assign irq_pending = latch_q;
  assign irq_out = irq_out_q;
  assign rdata = rdata_q;
endmodule
`default_nettype wire

// *** tb/eir_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module eir_props #(parameter int PORT_W = 8) (
  input wire logic clk,
  input wire logic rst,
  input wire logic irq_n,
  input wire logic [PORT_W-1:0] port_a_pins_in,
  input wire logic [PORT_W-1:0] port_a_pins_oe,
  input wire logic [PORT_W-1:0] port_a_pullup_en,
  input wire logic instr_done,
  input wire logic cc_irq_mask,
  input wire logic irq_take,
  input wire logic irq_pending
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // request line as the latch sees it
  wire line = irq_n & (&(port_a_pins_in | ~port_a_pullup_en));
  pend_set_a: assert property ($fell(line) && $stable(port_a_pullup_en) |-> ##3 irq_pending) else $error("no latch");
  no_done_a: assert property (!instr_done |=> !irq_take) else $error("take mid instr");
  take_go_a: assert property (instr_done && irq_pending && !cc_irq_mask |=> irq_take) else $error("no take");
  take_why_a: assert property (irq_take |-> $past(irq_pending) && !$past(cc_irq_mask)) else $error("bad take");
  port_in_a: assert property ($fell(rst) |-> port_a_pins_oe == 8'h00) else $error("port drives");
  rst_clr_a: assert property ($fell(rst) |-> !irq_pending && !irq_take) else $error("latch kept");
  take_clr_a: assert property (irq_take && $past(line, 2) && $past(line, 3) && $past(line, 4) |-> !irq_pending)
    else $error("latch not cleared");
  // main scenarios reached
  cover property (irq_take);
  cover property (irq_pending && cc_irq_mask && instr_done);
  cover property (irq_take && irq_pending);
endmodule
bind eir_top eir_props #(.PORT_W(PORT_W)) props (.clk, .rst, .irq_n, .port_a_pins_in, .port_a_pins_oe,
  .port_a_pullup_en, .instr_done, .cc_irq_mask, .irq_take, .irq_pending);
`default_nettype wire

// *** tb/eir_ext.sv ***
`timescale 1ns/1ns
`default_nettype none
// outside devices pulling the request pin and port A pins low
module eir_ext (
  input wire logic pull,
  input wire logic [7:0] pull_pa,
  input wire logic [7:0] pins_out,
  input wire logic [7:0] pins_oe,
  output logic irq_n,
  output logic [7:0] pins_in
);
  // pull-up keeps lines high when released
  assign irq_n = ~pull;
  assign pins_in = (pins_oe & pins_out) | (~pins_oe & ~pull_pa);
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 0, rst = 1, wr = 0, rd = 0, instr_done = 0, cc_irq_mask = 1, pull = 0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, pull_pa = 8'h00, rdata, pin, pout, poe, pu;
  logic irq_n, irq_take, irq_pending, irq_out;
  int fails = 0, tests_run = 0;
  // free-running clock
  always #4 clk = ~clk;
  eir_ext ext (.pull, .pull_pa, .pins_out(pout), .pins_oe(poe), .irq_n, .pins_in(pin));
  eir_top dut (.clk, .rst, .irq_n, .port_a_pins_in(pin), .port_a_pins_out(pout), .port_a_pins_oe(poe),
    .port_a_pullup_en(pu), .instr_done, .cc_irq_mask, .irq_take, .irq_pending, .irq_out, .addr, .wdata,
    .wr, .rd, .rdata);
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(logic [2:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rreg(logic [2:0] a, logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1;
    chk("rdata", e, rdata);
  endtask
  // one instruction completes with the given mask flag
  task automatic done(logic m, logic t, logic p);
    @(posedge clk);
    cc_irq_mask <= m;
    instr_done <= 1;
    @(posedge clk);
    instr_done <= 0;
    #1;
    chk("take", t, irq_take);
    chk("pend", p, irq_pending);
  endtask
  task automatic t_edge();
    wreg(3'h1, 8'h01);
    pull <= 1;
    cyc(6);
    chk("pend", 1, irq_pending);
    chk("irq", 1, irq_out);
    done(1, 0, 1);
    done(0, 1, 0);
    @(posedge clk);
    pull <= 0;
    rreg(3'h0, 8'h03);
    wreg(3'h0, 8'h03);
    rreg(3'h0, 8'h00);
    wreg(3'h7, 8'hFF);
    rreg(3'h7, 8'h00);
    rreg(3'h1, 8'h01);
    chk("irq", 0, irq_out);
  endtask
  task automatic t_level();
    wreg(3'h4, 8'h01);
    pull <= 1;
    cyc(6);
    done(0, 1, 1);
    @(posedge clk);
    pull <= 0;
    cyc(6);
    done(0, 1, 0);
    rreg(3'h4, 8'h01);
    wreg(3'h4, 8'h00);
  endtask
  task automatic t_port();
    @(posedge clk);
    pull_pa <= 8'h10;
    cyc(6);
    chk("pend", 0, irq_pending);
    rreg(3'h6, 8'hEF);
    wreg(3'h5, 8'h08);
    pull_pa <= 8'h18;
    cyc(6);
    chk("pend", 1, irq_pending);
    chk("pullup", 8'h08, pu);
    rreg(3'h5, 8'h08);
    done(0, 1, 0);
    wreg(3'h2, 8'hA5);
    @(posedge clk);
    pull_pa <= 8'h00;
    wreg(3'h3, 8'hFF);
    cyc(1);
    chk("oe", 8'hFF, poe);
    chk("out", 8'hA5, pout);
    rreg(3'h2, 8'hA5);
    @(posedge clk);
    rst <= 1;
    repeat (3) @(posedge clk);
    rst <= 0;
    #1;
    chk("oe", 8'h00, poe);
    chk("pullup", 8'h00, pu);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    t_edge();
    t_level();
    t_port();
    complete_run();
  end
  // watchdog
  initial begin
    #20000;
    fails++;
    complete_run();
  end
endmodule
`default_nettype wire
